// *** drive_modbus_register_map.sv ***
// register bank of the drive as seen from the serial-link master
// assumes a framer on the same clock hands over decoded requests and sends the answers
// Summary of operation
// - command block COMMAND_RESERVED_WORD is read and written
// - monitor block MONITOR_RESERVED_WORD is read only
// - operation command: run, reverse, fault, reset, terminals
// - 2402H holds frequency command, 0.01 Hz
// - 2403H holds signed torque command, +-16384
// - status bits 0-4: run, reverse, hold, fault, alarm
// - status bits 5-10 further flags, 11-15 zero
// - 2423H reports output frequency, 0.01 Hz
// - 2424H reports output current, 0.1 A
// - 2425H reports output voltage, 0.1 V
// - 2426H reports bus voltage, 0.1 V
// - TERMINAL_IO_FLAGS reports input terminals, relays, auxiliary output
// - ANALOG_IN_ONE_VALUE reports first analogue input, 0-1000
// - ANALOG_IN_TWO_VALUE reports second analogue input, 0-1000
// - ANALOG_OUT_ONE_VALUE, ANALOG_OUT_TWO_VALUE report signed analogue outputs
// - 2427H holds alarm code, zero none
// - read 03H, single write 06H, echoed answers
// - multi write 10H, at most twenty words
// - errors answer function with bit 7, code
`timescale 1ns/1ps

module drive_modbus_register_map
    import drive_regmap_pkg::*;
#(
    parameter logic [15:0] WRITE_MAX = WRITE_MULTI_MAX,
    parameter logic [15:0] READ_MAX  = READ_MULTI_MAX
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    // request from the framer
    input  wire logic        i_req_valid,
    input  wire logic [7:0]  i_req_func,
    input  wire logic [15:0] i_req_addr,
    input  wire logic [15:0] i_req_qty,
    input  wire logic [15:0] i_req_data,
    output logic             o_req_ready,
    // data words of a multi write
    input  wire logic        i_wr_valid,
    input  wire logic [15:0] i_wr_data,
    output logic             o_wr_ready,
    // answer header and read words
    output logic             o_rsp_valid,
    output logic [7:0]       o_rsp_func,
    output logic [15:0]      o_rsp_addr,
    output logic [15:0]      o_rsp_value,
    output logic             o_rsp_exception,
    output logic             o_rd_valid,
    output logic [15:0]      o_rd_addr,
    output logic [15:0]      o_rd_data,
    // local warning of a refused request
    output logic             o_communication_warning_display,
    output logic [7:0]       o_warning_code,
    // commands towards the drive
    output logic             o_run_cmd,
    output logic             o_reverse_cmd,
    output logic             o_option_card_external_fault,
    output logic             o_fault_reset_cmd,
    output logic [7:0]       o_terminal_force,
    output logic [15:0]      o_freq_setpoint,
    output logic [15:0]      o_torque_setpoint,
    // drive state to be monitored
    input  wire logic [10:0] i_run_state_flags,
    input  wire logic [15:0] i_active_freq,
    input  wire logic [15:0] i_output_freq,
    input  wire logic [15:0] i_output_current,
    input  wire logic [15:0] i_output_voltage,
    input  wire logic [15:0] i_bus_voltage,
    input  wire logic [4:0]  i_alarm_code,
    input  wire logic [6:0]  i_fault_code,
    input  wire logic [7:0]  i_input_terminals,
    input  wire logic        i_relay_one,
    input  wire logic        i_relay_two,
    input  wire logic        i_auxiliary_output_one,
    input  wire logic [15:0] i_analog_input_one,
    input  wire logic [15:0] i_analog_input_two,
    input  wire logic [15:0] i_analog_output_one,
    input  wire logic [15:0] i_analog_output_two
);

    // ************************************************************
    // state of the bank
    // ************************************************************
    typedef struct packed {
        req_state_e  st;
        logic [15:0] op_cmd;
        logic [15:0] freq_sp;
        logic [15:0] torque_sp;
        logic [15:0] addr;
        logic [15:0] left;
        logic        rsp_valid;
        logic [7:0]  rsp_func;
        logic [15:0] rsp_addr;
        logic [15:0] rsp_value;
        logic        rsp_exc;
        logic        rd_valid;
        logic [15:0] rd_addr;
        logic [15:0] rd_data;
        logic        warn;
        logic [7:0]  warn_code;
    } bank_s;

    localparam bank_s BANK_RESET = '{
        st:        ST_IDLE,
        op_cmd:    OPCMD_RESET_VALUE,
        freq_sp:   FREQ_RESET_VALUE,
        torque_sp: TORQUE_RESET_VALUE,
        addr:      16'h0000,
        left:      16'h0000,
        rsp_valid: 1'b0,
        rsp_func:  8'h00,
        rsp_addr:  16'h0000,
        rsp_value: 16'h0000,
        rsp_exc:   1'b0,
        rd_valid:  1'b0,
        rd_addr:   16'h0000,
        rd_data:   16'h0000,
        warn:      1'b0,
        warn_code: EXC_NONE
    };

    bank_s q;
    bank_s d;

    // ************************************************************
    // helpers
    // ************************************************************

    // whole span of qty words from addr lies in [lo, hi]
    function automatic logic span_ok(input logic [15:0] addr, input logic [15:0] qty,
                                     input logic [15:0] lo, input logic [15:0] hi);
        logic [16:0] last;
        last = {1'b0, addr} + {1'b0, qty} - 17'h00001;
        return (addr >= lo) && (last <= {1'b0, hi});
    endfunction : span_ok

    // store one word into the command block
    function automatic bank_s write_cmd(input bank_s s, input logic [15:0] addr,
                                        input logic [15:0] data);
        bank_s r;
        r = s;
        unique case (addr)
            OPERATION_COMMAND:  r.op_cmd    = data & OPCMD_WRITE_MASK;
            FREQUENCY_SETPOINT: r.freq_sp   = data;
            TORQUE_SETPOINT:    r.torque_sp = data;
            default:            r           = s;
        endcase
        return r;
    endfunction : write_cmd

    // value of one register as the master sees it
    function automatic logic [15:0] read_word(input logic [15:0] addr);
        logic [15:0] v;
        v = 16'h0000;
        unique case (addr)
            OPERATION_COMMAND:  v = q.op_cmd;
            FREQUENCY_SETPOINT: v = q.freq_sp;
            TORQUE_SETPOINT:    v = q.torque_sp;
            RUN_STATE_FLAGS:    v = {5'h00, i_run_state_flags};
            ACTIVE_FREQ_SP:     v = i_active_freq;
            OUTPUT_FREQ_VALUE:  v = i_output_freq;
            OUTPUT_CURR_VALUE:  v = i_output_current;
            OUTPUT_VOLT_VALUE:  v = i_output_voltage;
            BUS_VOLT_VALUE:     v = i_bus_voltage;
            ALARM_CODE:         v = {11'h000, i_alarm_code};
            FAULT_CODE:         v = {9'h000, i_fault_code};
            TERMINAL_IO_FLAGS: begin
                v[7:0]               = i_input_terminals;
                v[TERM_RELAY_ONE_BIT] = i_relay_one;
                v[TERM_RELAY_TWO_BIT] = i_relay_two;
                v[TERM_AUX_OUT_BIT]   = i_auxiliary_output_one;
            end
            ANALOG_IN_ONE:      v = i_analog_input_one;
            ANALOG_IN_TWO:      v = i_analog_input_two;
            ANALOG_OUT_ONE:     v = i_analog_output_one;
            ANALOG_OUT_TWO:     v = i_analog_output_two;
            default:            v = 16'h0000;
        endcase
        return v;
    endfunction : read_word

    // ************************************************************
    // request engine
    // ************************************************************

    // next state of the whole bank
    always_comb begin
        logic [7:0] exc;
        exc         = EXC_NONE;
        d           = q;
        d.rsp_valid = 1'b0;
        d.rd_valid  = 1'b0;
        unique case (q.st)
            ST_IDLE: begin
                if (i_req_valid) begin
                    d.rsp_func  = i_req_func;
                    d.rsp_addr  = i_req_addr;
                    d.rsp_exc   = 1'b0;
                    d.addr      = i_req_addr;
                    d.left      = i_req_qty;
                    if (i_req_func == FUNC_READ_REGS) begin
                        if (i_req_qty == 16'h0000 || i_req_qty > READ_MAX) begin
                            exc = EXC_BAD_VALUE;
                        end else if (!span_ok(i_req_addr, i_req_qty, CMD_BLOCK_FIRST,
                                              CMD_BLOCK_LAST) &&
                                     !span_ok(i_req_addr, i_req_qty, MON_BLOCK_FIRST,
                                              MON_BLOCK_LAST)) begin
                            exc = EXC_BAD_ADDRESS;
                        end else begin
                            d.rsp_valid = 1'b1;
                            d.rsp_value = {i_req_qty[14:0], 1'b0};
                            d.st        = ST_READ;
                        end
                    end else if (i_req_func == FUNC_WRITE_ONE) begin
                        if (!span_ok(i_req_addr, 16'h0001, CMD_BLOCK_FIRST,
                                     CMD_BLOCK_LAST)) begin
                            exc = EXC_BAD_ADDRESS;
                        end else begin
                            d           = write_cmd(d, i_req_addr, i_req_data);
                            d.rsp_valid = 1'b1;
                            d.rsp_value = i_req_data;
                        end
                    end else if (i_req_func == FUNC_WRITE_MULTI) begin
                        if (i_req_qty == 16'h0000 || i_req_qty > WRITE_MAX) begin
                            exc = EXC_BAD_VALUE;
                        end else if (!span_ok(i_req_addr, i_req_qty, CMD_BLOCK_FIRST,
                                              CMD_BLOCK_LAST)) begin
                            exc = EXC_BAD_ADDRESS;
                        end else begin
                            d.rsp_value = i_req_qty;
                            d.st        = ST_WRITE;
                        end
                    end else begin
                        exc = EXC_BAD_FUNCTION;
                    end
                    // refused request: flagged function, code, local warning
                    if (exc != EXC_NONE) begin
                        d.rsp_valid = 1'b1;
                        d.rsp_exc   = 1'b1;
                        d.rsp_func  = i_req_func | FUNC_ERROR_FLAG;
                        d.rsp_value = {8'h00, exc};
                        d.warn      = 1'b1;
                        d.warn_code = exc;
                    end else begin
                        d.warn      = 1'b0;
                        d.warn_code = EXC_NONE;
                    end
                end
            end
            ST_READ: begin
                // one word per cycle, incrementing address
                d.rd_valid = 1'b1;
                d.rd_addr  = q.addr;
                d.rd_data  = read_word(q.addr);
                d.addr     = q.addr + 16'h0001;
                d.left     = q.left - 16'h0001;
                if (q.left == 16'h0001) begin
                    d.st = ST_IDLE;
                end
            end
            ST_WRITE: begin
                // one data word taken per accepted strobe
                if (i_wr_valid) begin
                    d      = write_cmd(d, q.addr, i_wr_data);
                    d.addr = q.addr + 16'h0001;
                    d.left = q.left - 16'h0001;
                    if (q.left == 16'h0001) begin
                        d.st        = ST_IDLE;
                        d.rsp_valid = 1'b1;
                    end
                end
            end
        endcase
    end

    // register the bank
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            q <= BANK_RESET;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************

    // handshakes from state, data from flops
    assign o_req_ready                     = (q.st == ST_IDLE);
    assign o_wr_ready                      = (q.st == ST_WRITE);
    assign o_rsp_valid                     = q.rsp_valid;
    assign o_rsp_func                      = q.rsp_func;
    assign o_rsp_addr                      = q.rsp_addr;
    assign o_rsp_value                     = q.rsp_value;
    assign o_rsp_exception                 = q.rsp_exc;
    assign o_rd_valid                      = q.rd_valid;
    assign o_rd_addr                       = q.rd_addr;
    assign o_rd_data                       = q.rd_data;
    assign o_communication_warning_display = q.warn;
    assign o_warning_code                  = q.warn_code;

    // command fields to the drive
    assign o_run_cmd                    = q.op_cmd[OPCMD_RUN_BIT];
    assign o_reverse_cmd                = q.op_cmd[OPCMD_REVERSE_BIT];
    assign o_option_card_external_fault = q.op_cmd[OPCMD_EXT_FAULT_BIT];
    assign o_fault_reset_cmd            = q.op_cmd[OPCMD_RESET_BIT];
    assign o_terminal_force             = q.op_cmd[OPCMD_TERM_LSB +: 8];
    assign o_freq_setpoint              = q.freq_sp;
    assign o_torque_setpoint            = q.torque_sp;

    // ************************************************************
    // checks
    // ************************************************************

    freq_readback_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (o_rsp_valid && !o_rsp_exception && o_rsp_func == FUNC_WRITE_ONE &&
         o_rsp_addr == FREQUENCY_SETPOINT) |-> (o_freq_setpoint == o_rsp_value))
        else $error("frequency write not stored");

    monitor_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (o_req_ready && i_req_valid && i_req_func == FUNC_WRITE_ONE &&
         i_req_addr >= MON_BLOCK_FIRST && i_req_addr <= MON_BLOCK_LAST)
        |=> (o_rsp_valid && o_rsp_exception && $stable(o_freq_setpoint)))
        else $error("monitor write not refused");

    opcmd_reserved_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (o_rd_valid && o_rd_addr == OPERATION_COMMAND) |-> (o_rd_data[7:4] == 4'h0))
        else $error("reserved command bits not zero");

    error_answer_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (o_rsp_valid && o_rsp_exception)
        |-> (o_rsp_func[7] && o_communication_warning_display &&
             o_rsp_value[7:0] == o_warning_code))
        else $error("error answer malformed");

    multi_limit_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (o_req_ready && i_req_valid && i_req_func == FUNC_WRITE_MULTI && i_req_qty > WRITE_MAX)
        |=> (o_rsp_valid && o_rsp_value == {8'h00, EXC_BAD_VALUE}))
        else $error("oversize multi write accepted");

    read_stream_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (o_rsp_valid && !o_rsp_exception && o_rsp_func == FUNC_READ_REGS)
        |=> (o_rd_valid && o_rd_addr == $past(o_rsp_addr)))
        else $error("read words do not follow header");

    status_reserved_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (o_rd_valid && o_rd_addr == RUN_STATE_FLAGS)
        |-> (o_rd_data == {5'h00, $past(i_run_state_flags)}))
        else $error("status word wrong");

    terminal_map_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (o_rd_valid && o_rd_addr == TERMINAL_IO_FLAGS)
        |-> (o_rd_data[7:0] == $past(i_input_terminals) &&
             o_rd_data[TERM_AUX_OUT_BIT] == $past(i_auxiliary_output_one) &&
             o_rd_data[11:8] == 4'h0 && !o_rd_data[15]))
        else $error("terminal word wrong");

    reserved_word_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (o_rd_valid && (o_rd_addr == COMMAND_RESERVED || o_rd_addr == MONITOR_RESERVED ||
                        o_rd_addr == MONITOR_RESERVED_B)) |-> (o_rd_data == 16'h0000))
        else $error("reserved word not zero");

endmodule : drive_modbus_register_map

// *** drive_regmap_pkg.sv ***
// constants for the drive's serial-link register bank
// assumes a 16-bit register space reached by read, single write and multi write requests
package drive_regmap_pkg;

    // ************************************************************
    // register addresses
    // ************************************************************
    localparam logic [15:0] CMD_BLOCK_FIRST     = 16'h2400;
    localparam logic [15:0] CMD_BLOCK_LAST      = 16'h2403;
    localparam logic [15:0] MON_BLOCK_FIRST     = 16'h2420;
    localparam logic [15:0] MON_BLOCK_LAST      = 16'h242E;
    localparam logic [15:0] COMMAND_RESERVED    = 16'h2400;
    localparam logic [15:0] OPERATION_COMMAND   = 16'h2401;
    localparam logic [15:0] FREQUENCY_SETPOINT  = 16'h2402;
    localparam logic [15:0] TORQUE_SETPOINT     = 16'h2403;
    localparam logic [15:0] MONITOR_RESERVED    = 16'h2420;
    localparam logic [15:0] RUN_STATE_FLAGS     = 16'h2421;
    localparam logic [15:0] ACTIVE_FREQ_SP      = 16'h2422;
    localparam logic [15:0] OUTPUT_FREQ_VALUE   = 16'h2423;
    localparam logic [15:0] OUTPUT_CURR_VALUE   = 16'h2424;
    localparam logic [15:0] OUTPUT_VOLT_VALUE   = 16'h2425;
    localparam logic [15:0] BUS_VOLT_VALUE      = 16'h2426;
    localparam logic [15:0] ALARM_CODE          = 16'h2427;
    localparam logic [15:0] FAULT_CODE          = 16'h2428;
    localparam logic [15:0] TERMINAL_IO_FLAGS   = 16'h2429;
    localparam logic [15:0] ANALOG_IN_ONE       = 16'h242A;
    localparam logic [15:0] ANALOG_IN_TWO       = 16'h242B;
    localparam logic [15:0] MONITOR_RESERVED_B  = 16'h242C;
    localparam logic [15:0] ANALOG_OUT_ONE      = 16'h242D;
    localparam logic [15:0] ANALOG_OUT_TWO      = 16'h242E;

    // ************************************************************
    // field layouts and reset values
    // ************************************************************
    localparam int          OPCMD_RUN_BIT       = 0;
    localparam int          OPCMD_REVERSE_BIT   = 1;
    localparam int          OPCMD_EXT_FAULT_BIT = 2;
    localparam int          OPCMD_RESET_BIT     = 3;
    localparam int          OPCMD_TERM_LSB      = 8;
    localparam logic [15:0] OPCMD_WRITE_MASK    = 16'hFF0F;
    localparam int          TERM_RELAY_ONE_BIT  = 12;
    localparam int          TERM_RELAY_TWO_BIT  = 13;
    localparam int          TERM_AUX_OUT_BIT    = 14;
    localparam logic [15:0] OPCMD_RESET_VALUE   = 16'h0000;
    localparam logic [15:0] FREQ_RESET_VALUE    = 16'h0000;
    localparam logic [15:0] TORQUE_RESET_VALUE  = 16'h0000;

    // ************************************************************
    // function and exception codes, limits
    // ************************************************************
    localparam logic [7:0]  FUNC_READ_REGS      = 8'h03;
    localparam logic [7:0]  FUNC_WRITE_ONE      = 8'h06;
    localparam logic [7:0]  FUNC_WRITE_MULTI    = 8'h10;
    localparam logic [7:0]  FUNC_ERROR_FLAG     = 8'h80;
    localparam logic [7:0]  EXC_NONE            = 8'h00;
    localparam logic [7:0]  EXC_BAD_FUNCTION    = 8'h01;
    localparam logic [7:0]  EXC_BAD_ADDRESS     = 8'h02;
    localparam logic [7:0]  EXC_BAD_VALUE       = 8'h03;
    localparam logic [15:0] WRITE_MULTI_MAX     = 16'h0014;
    localparam logic [15:0] READ_MULTI_MAX      = 16'h000F;

    // ************************************************************
    // request engine states
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } req_state_e;

endpackage : drive_regmap_pkg

// *** drive_master_model.sv ***
// master-side model that hands decoded requests and data words to the bank
// assumes the bank takes a request or word on a rising edge while ready is high
`timescale 1ns/1ps
module drive_master_model (
    input  wire logic   i_clk_sys,
    input  wire logic   i_req_ready,
    input  wire logic   i_wr_ready,
    output logic        o_req_valid = 1'b0,
    output logic [7:0]  o_req_func = 8'h00,
    output logic [15:0] o_req_addr = 16'h0000,
    output logic [15:0] o_req_qty = 16'h0000,
    output logic [15:0] o_req_data = 16'h0000,
    output logic        o_wr_valid = 1'b0,
    output logic [15:0] o_wr_data = 16'h0000
);
    // request held to the ready edge, data inverted once released
    task automatic req(input logic [7:0] f, input logic [15:0] a, q, d);
        @(negedge i_clk_sys);
        {o_req_valid, o_req_func, o_req_addr, o_req_qty, o_req_data} = {1'b1, f, a, q, d};
        while (i_req_ready !== 1'b1) @(negedge i_clk_sys);
        @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        o_req_valid = 1'b0;
        o_req_data = ~d;
    endtask : req
    // one multi-write word, left up for the next one
    task automatic word(input logic [15:0] d);
        @(negedge i_clk_sys);
        {o_wr_valid, o_wr_data} = {1'b1, d};
        while (i_wr_ready !== 1'b1) @(negedge i_clk_sys);
        @(posedge i_clk_sys);
    endtask : word
    // close a word stream
    task automatic wend;
        @(negedge i_clk_sys);
        o_wr_valid = 1'b0;
        o_wr_data = ~o_wr_data;
    endtask : wend
endmodule : drive_master_model

// *** test_drive_modbus_register_map.sv ***
// self-checking bench for the drive register bank
// assumes a 10 MHz clock and a synchronous active-low reset
`timescale 1ns/1ps
module test_drive_modbus_register_map;
    import drive_regmap_pkg::*;
    logic        i_clk_sys = 1'b0, i_reset_n = 1'b0, rx;
    logic        i_req_valid, i_wr_valid, o_req_ready, o_wr_ready, o_rsp_valid, o_rd_valid;
    logic        o_rsp_exception, o_communication_warning_display, o_run_cmd, o_reverse_cmd;
    logic        o_fault_reset_cmd, o_option_card_external_fault;
    logic        i_relay_one, i_relay_two, i_auxiliary_output_one;
    logic [4:0]  i_alarm_code;
    logic [6:0]  i_fault_code;
    logic [10:0] i_run_state_flags;
    logic [7:0]  i_req_func, o_rsp_func, o_warning_code, o_terminal_force, i_input_terminals, rf;
    logic [15:0] i_req_addr, i_req_qty, i_req_data, i_wr_data, o_rsp_addr, o_rsp_value, o_rd_addr;
    logic [15:0] o_rd_data, o_freq_setpoint, o_torque_setpoint, i_active_freq, i_output_freq;
    logic [15:0] i_output_current, i_output_voltage, i_bus_voltage, i_analog_input_one, ra, ga;
    logic [15:0] i_analog_input_two, i_analog_output_one, i_analog_output_two, rv, op, fq, tq, rd;
    logic [7:0]  bf [8] = '{8'h06, 8'h10, 8'h03, 8'h03, 8'h07, 8'h10, 8'h10, 8'h03};
    logic [15:0] ba [8] = '{16'h2421, 16'h2401, 16'h2421, 16'h2403, 16'h2401, 16'h2402, 16'h2401,
                            16'h2420};
    logic [15:0] bq [8] = '{16'h0001, 16'h0000, 16'h0000, 16'h0002, 16'h0001, 16'h0003, 16'h0015,
                            16'h0010};
    logic [7:0]  bx [8] = '{8'h02, 8'h03, 8'h03, 8'h02, 8'h01, 8'h02, 8'h03, 8'h03};
    int          err_total = 0, n_tests = 0, seed = 1, nr = 0, nr0, k, j;

    drive_modbus_register_map drive_modbus_register_map_i (.*);
    drive_master_model drive_master_model_i (.i_clk_sys(i_clk_sys), .i_req_ready(o_req_ready),
        .i_wr_ready(o_wr_ready), .o_req_valid(i_req_valid), .o_req_func(i_req_func),
        .o_req_addr(i_req_addr), .o_req_qty(i_req_qty), .o_req_data(i_req_data),
        .o_wr_valid(i_wr_valid), .o_wr_data(i_wr_data));

    always #50 i_clk_sys = ~i_clk_sys;

    // expected content of any register
    function automatic logic [15:0] exp_reg(input logic [15:0] a);
        case (a)
            OPERATION_COMMAND:  return op & OPCMD_WRITE_MASK;
            FREQUENCY_SETPOINT: return fq;
            TORQUE_SETPOINT:    return tq;
            RUN_STATE_FLAGS:    return {5'h00, i_run_state_flags};
            ACTIVE_FREQ_SP:     return i_active_freq;
            OUTPUT_FREQ_VALUE:  return i_output_freq;
            OUTPUT_CURR_VALUE:  return i_output_current;
            OUTPUT_VOLT_VALUE:  return i_output_voltage;
            BUS_VOLT_VALUE:     return i_bus_voltage;
            ALARM_CODE:         return {11'h000, i_alarm_code};
            FAULT_CODE:         return {9'h000, i_fault_code};
            TERMINAL_IO_FLAGS:  return {1'b0, i_auxiliary_output_one, i_relay_two, i_relay_one,
                                        4'h0, i_input_terminals};
            ANALOG_IN_ONE:      return i_analog_input_one;
            ANALOG_IN_TWO:      return i_analog_input_two;
            ANALOG_OUT_ONE:     return i_analog_output_one;
            ANALOG_OUT_TWO:     return i_analog_output_two;
            default:            return 16'h0000;
        endcase
    endfunction : exp_reg

    // drive state with random monitor values
    task automatic rnd(input int n);
        {i_run_state_flags, i_active_freq, i_output_freq, i_output_current} =
            59'({$random(seed), $random(seed)});
        {i_output_voltage, i_bus_voltage, i_fault_code, i_input_terminals, i_relay_one,
         i_relay_two, i_auxiliary_output_one} = 50'({$random(seed), $random(seed)});
        {i_analog_input_one, i_analog_input_two, i_analog_output_one, i_analog_output_two} =
            {$random(seed), $random(seed)};
        i_alarm_code = 5'(n % 22);
    endtask : rnd

    task automatic chk(input logic ok, input string s);
        n_tests++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH %0t %s", $time, s);
        end
    endtask : chk

    task automatic go(input logic [7:0] f, input logic [15:0] a, q, d);
        {nr0, ga, rd} = {nr, a, a};
        drive_master_model_i.req(f, a, q, d);
    endtask : go

    // wait for the answer and the read words, then compare header and commands
    task automatic done(input logic [7:0] f, input logic [15:0] v, input logic x);
        for (j = 0; j < 60 && (nr == nr0 || o_req_ready !== 1'b1); j++) @(negedge i_clk_sys);
        @(negedge i_clk_sys);
        chk(j < 60 && rf === f && rv === v && rx === x && ra === ga, "answer header");
        chk(o_communication_warning_display === x && o_warning_code === (x ? v[7:0] : 8'h00),
            "warning");
        chk({o_terminal_force, 4'h0, o_fault_reset_cmd, o_option_card_external_fault,
             o_reverse_cmd, o_run_cmd, o_freq_setpoint, o_torque_setpoint} ===
            {op & OPCMD_WRITE_MASK, fq, tq}, "command outputs");
    endtask : done

    // answer capture and read word checks
    always @(negedge i_clk_sys) begin
        if (o_rsp_valid === 1'b1) begin
            {rf, rv, rx, ra} = {o_rsp_func, o_rsp_value, o_rsp_exception, o_rsp_addr};
            nr++;
        end
        if (o_rd_valid === 1'b1) begin
            chk(o_rd_addr === rd && o_rd_data === exp_reg(rd), "read word");
            rd++;
        end
    end

    task automatic results;
        if (err_total == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge i_clk_sys);
        err_total++;
        results();
    end

    initial begin
        rnd(0);
        {op, fq, tq} = '0;
        repeat (3) @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        chk(o_req_ready === 1'b1 && o_wr_ready === 1'b0 && o_run_cmd === 1'b0, "reset state");
        for (k = 0; k < 4; k++) begin
            op = 16'($random(seed));
            go(FUNC_WRITE_ONE, OPERATION_COMMAND, 16'h0001, op);
            done(FUNC_WRITE_ONE, op, 1'b0);
            fq = 16'($random(seed));
            go(FUNC_WRITE_ONE, FREQUENCY_SETPOINT, 16'h0001, fq);
            done(FUNC_WRITE_ONE, fq, 1'b0);
            tq = (k == 0) ? 16'hC000 : (k == 1) ? 16'h4000 : 16'($random(seed) % 16385);
            go(FUNC_WRITE_ONE, TORQUE_SETPOINT, 16'h0001, tq);
            done(FUNC_WRITE_ONE, tq, 1'b0);
            go(FUNC_WRITE_ONE, COMMAND_RESERVED, 16'h0001, 16'hFFFF);
            done(FUNC_WRITE_ONE, 16'hFFFF, 1'b0);
            go(FUNC_READ_REGS, CMD_BLOCK_FIRST, 16'h0004, 16'h0000);
            done(FUNC_READ_REGS, 16'h0008, 1'b0);
            rnd(k * 7);
            go(FUNC_READ_REGS, MON_BLOCK_FIRST, READ_MULTI_MAX, 16'h0000);
            done(FUNC_READ_REGS, 16'h001E, 1'b0);
            {op, fq, tq} = {$random(seed), 16'($random(seed))};
            go(FUNC_WRITE_MULTI, OPERATION_COMMAND, 16'h0003, 16'h0000);
            drive_master_model_i.word(op);
            drive_master_model_i.word(fq);
            drive_master_model_i.word(tq);
            drive_master_model_i.wend();
            done(FUNC_WRITE_MULTI, 16'h0003, 1'b0);
        end
        for (k = 0; k < 8; k++) begin
            go(bf[k], ba[k], bq[k], 16'h1234);
            done(bf[k] | FUNC_ERROR_FLAG, {8'h00, bx[k]}, 1'b1);
        end
        go(FUNC_WRITE_ONE, FREQUENCY_SETPOINT, 16'h0001, fq);
        done(FUNC_WRITE_ONE, fq, 1'b0);
        results();
    end
endmodule : test_drive_modbus_register_map
